/* hdl/pdm_pkg.sv */
// Constants, register map and state type for the power-down mode controller.
// Assumes a 32-bit APB slave port; registers sit in the low byte of each word.
package pdm_pkg;

   // Register byte offsets
   localparam logic [7:0] ADDR_MSTOP_B   = 8'h00;
   localparam logic [7:0] ADDR_MSTOP_C   = 8'h04;
   localparam logic [7:0] ADDR_EXT_STOP  = 8'h08;
   localparam logic [7:0] ADDR_STANDBY_PIN_N_CTRL = 8'h0C;
   localparam logic [7:0] ADDR_CLK_CTRL  = 8'h10;
   localparam logic [7:0] ADDR_LPW_CTRL  = 8'h14;
   localparam logic [7:0] ADDR_PSC_CTRL  = 8'h18;
   localparam logic [7:0] ADDR_STATUS    = 8'h1C;

   // Reset values
   localparam logic [7:0] MSTOP_B_RST    = 8'hFF;
   localparam logic [7:0] MSTOP_C_RST    = 8'hFD;
   localparam logic [1:0] EXT_STOP_RST   = 2'h0;
   localparam logic [2:0] DIV_FULL       = 3'h0;
   localparam logic [2:0] STS_RST        = 3'h0;

   // Field positions
   localparam int MSB_SCI0     = 7;
   localparam int MSB_SCI2     = 5;
   localparam int MSB_USB      = 0;
   localparam int MSC_FLASH    = 1;
   localparam int MSC_DEBUG    = 0;
   localparam int EXT_RTC      = 1;
   localparam int EXT_USB      = 0;
   localparam int SBY_SOFTWARE_STANDBY_SELECT     = 7;
   localparam int SBY_STS_LO   = 4;
   localparam int LPW_LOW_SPEED_SELECT     = 0;
   localparam int PSC_PSS      = 4;
   localparam int STAT_DIV_LO  = 4;

   // Settling codes and the counts that fit under the long-count limit
   localparam logic [2:0]  STS_2048   = 3'h6;
   localparam logic [2:0]  STS_16     = 3'h7;
   localparam int unsigned SETTLE_2048 = 2048;
   localparam int unsigned SETTLE_16   = 16;
   localparam int          CNT_W       = 19;

   // Pin synchroniser layout
   localparam int          SYNC_W   = 12;
   localparam int          SY_RES   = 11;
   localparam int          SY_MANUAL_RESET_PIN_N  = 10;
   localparam int          SY_STANDBY_PIN_N  = 9;
   localparam int          SY_NMI   = 8;
   localparam logic [11:0] SYNC_RST = 12'h200;

   typedef enum logic [2:0] {
      PDM_RUN,
      PDM_SLEEP,
      PDM_SW_STANDBY_PIN_N,
      PDM_SETTLE,
      PDM_HW_STANDBY_PIN_N,
      PDM_RESET
   } pdm_state_t;

endpackage

/* hdl/pdm_sync.sv */
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes inputs are levels; pulses shorter than one clock may be lost.
`timescale 1ns/100ps
module pdm_sync
#(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // One stage pair per bit; only the second stage is read outside
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               meta_reg[i] <= RST_VAL[i];
               sync_out[i] <= RST_VAL[i];
            end
            else
            begin
               meta_reg[i] <= async_in[i];
               sync_out[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

endmodule

/* hdl/pdm_power_ctrl.sv */
// Power-down mode controller: module stop, clock gates, medium speed,
// sleep, software standby with settling count, hardware standby.
// Assumes an APB master on pclk, pins arriving asynchronously.
//
// What this block does
// - Stop reg B bits 7,5,0 gate serial 0, serial 2, USB; reset to 1.
// - Unassigned stop bits are read/write, reset to 1; software writes 1.
// - Extended stop bit 1 gates RTC clock, bit 0 USB clock; reset 0.
// - Extended stop bits 7..2 read 0; software leaves them alone.
// - Nonzero divider select slows CPU after bus cycle; zero restores speed.
// - DMA master follows divided clock; other modules stay at full clock.
// - Reset pin, manual reset or watchdog overflow abandons medium speed.
// - Sleep with standby and low-speed bits 0 halts CPU only.
// - Enabled unmasked interrupt or NMI ends sleep; speed kept.
// - Reset pins low during sleep give reset; release starts reset handling.
// - Standby pin low enters hardware standby from any mode.
// - Sleep with standby 1, low-speed 0, prescaler 0 stops oscillator.
// - NMI, lines 0..7 and reset or standby pins leave software standby.
// - Interrupt wake restarts oscillator, waits settling count, then runs.
// - Reset in software standby starts oscillator and clocks at once.
// - Hardware standby resets and stops everything, ports high impedance.
// - Standby pin high with reset low enters reset, oscillator starts.
// - Settling code gives 8192..262144, 2048 or 16 states.
// - A stop bit at 1 stops its module; 0 releases it.
`timescale 1ns/100ps
module pdm_power_ctrl
   import pdm_pkg::*;
#(
   parameter int unsigned SETTLE_8192   = 8192,
   parameter int unsigned SETTLE_16384  = 16384,
   parameter int unsigned SETTLE_32768  = 32768,
   parameter int unsigned SETTLE_65536  = 65536,
   parameter int unsigned SETTLE_131072 = 131072,
   parameter int unsigned SETTLE_262144 = 262144
)
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Pins, asynchronous
   input  wire logic        reset_pin_n,
   input  wire logic        manual_reset_pin_n,
   input  wire logic        standby_pin_n,
   input  wire logic        nmi_req,
   input  wire logic [7:0]  irq_lines,
   // CPU and interrupt controller, same clock
   input  wire logic        sleep_req,
   input  wire logic        bus_cycle_end,
   input  wire logic        wdt_overflow,
   input  wire logic [7:0]  irq_enable,
   input  wire logic        periph_int_req,
   input  wire logic        cpu_int_mask,
   // Clock and power control
   output logic [2:0]       cpu_clk_div,
   output logic [2:0]       dma_clk_div,
   output logic             cpu_halt,
   output logic             clock_supply,
   output logic             osc_enable,
   output logic             chip_reset,
   output logic             io_hiz,
   output logic             converter_reset,
   output logic             reset_exc_start,
   output logic             int_exc_start,
   // Module stop and clock gates
   output logic             serial_channel_0_stop,
   output logic             serial_channel_2_stop,
   output logic             usb_stop,
   output logic             flash_stop,
   output logic             debug_interface_stop,
   output logic             rtc_clock_gate,
   output logic             usb_clock_gate
);

   logic [SYNC_W-1:0] sy;
   pdm_state_t        state_reg;
   pdm_state_t        state_next;
   logic [7:0]        module_stop_ctrl_b_reg;
   logic [7:0]        module_stop_ctrl_c_reg;
   logic [1:0]        extended_clock_stop_reg;
   logic              software_standby_select_reg;
   logic [2:0]        settling_count_select_reg;
   logic [2:0]        cpu_clock_divider_select_reg;
   logic              low_speed_select_reg;
   logic              prescaler_select_reg;
   logic [2:0]        active_div_reg;
   logic [CNT_W-1:0]  settle_cnt_reg;
   logic              reset_any;
   logic              standby_pin_n_low;
   logic              irq_hit;
   logic              sw_wake;
   logic              sleep_wake;
   logic              apb_access;
   logic              apb_done;
   logic              wr_en;

   // Settling count minus one for a given select code
   function automatic logic [CNT_W-1:0] settle_load(input logic [2:0] sel);
      logic [CNT_W-1:0] n;
      n = CNT_W'(SETTLE_8192);
      unique case (sel)
         3'h0:     n = CNT_W'(SETTLE_8192);
         3'h1:     n = CNT_W'(SETTLE_16384);
         3'h2:     n = CNT_W'(SETTLE_32768);
         3'h3:     n = CNT_W'(SETTLE_65536);
         3'h4:     n = CNT_W'(SETTLE_131072);
         3'h5:     n = CNT_W'(SETTLE_262144);
         STS_2048: n = CNT_W'(SETTLE_2048);
         STS_16:   n = CNT_W'(SETTLE_16);
      endcase
      settle_load = n - CNT_W'(1);
   endfunction

   // True for an address that holds a register
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == ADDR_MSTOP_B) || (a == ADDR_MSTOP_C) || (a == ADDR_EXT_STOP)
             || (a == ADDR_STANDBY_PIN_N_CTRL) || (a == ADDR_CLK_CTRL)
             || (a == ADDR_LPW_CTRL) || (a == ADDR_PSC_CTRL) || (a == ADDR_STATUS);
   endfunction

   // Pins pass two flip-flops before use
   pdm_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) u_sync
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({reset_pin_n, manual_reset_pin_n, standby_pin_n, nmi_req, irq_lines}),
      .sync_out (sy)
   );

   // Wake and reset conditions
   always_comb
   begin
      reset_any  = !sy[SY_RES] || !sy[SY_MANUAL_RESET_PIN_N] || wdt_overflow;
      standby_pin_n_low   = !sy[SY_STANDBY_PIN_N];
      irq_hit    = |(sy[7:0] & irq_enable);
      sw_wake    = sy[SY_NMI] || (irq_hit && !cpu_int_mask);
      sleep_wake = sy[SY_NMI] || ((irq_hit || periph_int_req) && !cpu_int_mask);
   end

   // Mode sequencing
   always_comb
   begin
      state_next = state_reg;
      if (standby_pin_n_low)
         state_next = PDM_HW_STANDBY_PIN_N;
      else if (reset_any)
         state_next = PDM_RESET;
      else
      begin
         unique case (state_reg)
            PDM_RUN:
            begin
               if (sleep_req && !software_standby_select_reg && !low_speed_select_reg)
                  state_next = PDM_SLEEP;
               else if (sleep_req && software_standby_select_reg
                        && !low_speed_select_reg && !prescaler_select_reg)
                  state_next = PDM_SW_STANDBY_PIN_N;
            end
            PDM_SLEEP:
               if (sleep_wake)
                  state_next = PDM_RUN;
            PDM_SW_STANDBY_PIN_N:
               if (sw_wake)
                  state_next = PDM_SETTLE;
            PDM_SETTLE:
               if (settle_cnt_reg == '0)
                  state_next = PDM_RUN;
            PDM_HW_STANDBY_PIN_N:
               state_next = PDM_RESET;
            PDM_RESET:
               state_next = PDM_RUN;
         endcase
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_reg <= PDM_RESET;
      else
         state_reg <= state_next;
   end

   // Settling counter, loaded every cycle of software standby
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         settle_cnt_reg <= '0;
      else if (state_reg == PDM_SW_STANDBY_PIN_N)
         settle_cnt_reg <= settle_load(settling_count_select_reg);
      else if (state_reg == PDM_SETTLE && settle_cnt_reg != '0)
         settle_cnt_reg <= settle_cnt_reg - CNT_W'(1);
   end

   // Power outputs follow the next state so they align with it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cpu_halt        <= 1'b1;
         clock_supply    <= 1'b1;
         osc_enable      <= 1'b1;
         chip_reset      <= 1'b1;
         io_hiz          <= 1'b0;
         converter_reset <= 1'b1;
         reset_exc_start <= 1'b0;
         int_exc_start   <= 1'b0;
      end
      else
      begin
         cpu_halt        <= state_next != PDM_RUN;
         clock_supply    <= state_next inside {PDM_RUN, PDM_SLEEP, PDM_RESET};
         osc_enable      <= !(state_next inside {PDM_SW_STANDBY_PIN_N, PDM_HW_STANDBY_PIN_N});
         chip_reset      <= state_next inside {PDM_RESET, PDM_HW_STANDBY_PIN_N};
         io_hiz          <= state_next == PDM_HW_STANDBY_PIN_N;
         converter_reset <= state_next inside {PDM_SW_STANDBY_PIN_N, PDM_SETTLE,
                                               PDM_HW_STANDBY_PIN_N, PDM_RESET};
         reset_exc_start <= state_reg == PDM_RESET && state_next == PDM_RUN;
         int_exc_start   <= (state_reg inside {PDM_SLEEP, PDM_SETTLE})
                            && state_next == PDM_RUN;
      end
   end

   // Active divider takes the select at the end of a bus cycle; reset or standby pin low returns it to full speed at once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         active_div_reg <= DIV_FULL;
      else if (reset_any || standby_pin_n_low)
         active_div_reg <= DIV_FULL;
      else if (bus_cycle_end)
         active_div_reg <= cpu_clock_divider_select_reg;
   end

   // CPU and DMA share the divided clock; other modules stay at full rate
   assign cpu_clk_div = active_div_reg;
   assign dma_clk_div = active_div_reg;

   // APB handshake: one wait state, then completion
   assign apb_access = psel && penable;
   assign apb_done   = apb_access && pready;
   assign wr_en      = apb_done && pwrite && pstrb[0];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= apb_access && !pready;
         pslverr <= apb_access && !pready && !reg_hit(paddr);
         prdata  <= '0;
         if (apb_access && !pready && !pwrite)
         begin
            unique case (paddr)
               ADDR_MSTOP_B:   prdata[7:0] <= module_stop_ctrl_b_reg;
               ADDR_MSTOP_C:   prdata[7:0] <= module_stop_ctrl_c_reg;
               ADDR_EXT_STOP:  prdata[1:0] <= extended_clock_stop_reg;
               ADDR_STANDBY_PIN_N_CTRL:
               begin
                  prdata[SBY_SOFTWARE_STANDBY_SELECT] <= software_standby_select_reg;
                  prdata[SBY_STS_LO +: 3] <= settling_count_select_reg;
               end
               ADDR_CLK_CTRL:  prdata[2:0] <= cpu_clock_divider_select_reg;
               ADDR_LPW_CTRL:  prdata[LPW_LOW_SPEED_SELECT] <= low_speed_select_reg;
               ADDR_PSC_CTRL:  prdata[PSC_PSS] <= prescaler_select_reg;
               ADDR_STATUS:
               begin
                  prdata[2:0] <= state_reg;
                  prdata[STAT_DIV_LO +: 3] <= active_div_reg;
               end
               default:        prdata <= '0;
            endcase
         end
      end
   end

   // Module stop and clock gate registers; reloaded with reset values by the chip reset state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         module_stop_ctrl_b_reg  <= MSTOP_B_RST;
         module_stop_ctrl_c_reg  <= MSTOP_C_RST;
         extended_clock_stop_reg <= EXT_STOP_RST;
      end
      else if (chip_reset)
      begin
         module_stop_ctrl_b_reg  <= MSTOP_B_RST;
         module_stop_ctrl_c_reg  <= MSTOP_C_RST;
         extended_clock_stop_reg <= EXT_STOP_RST;
      end
      else if (wr_en)
      begin
         if (paddr == ADDR_MSTOP_B)
            module_stop_ctrl_b_reg <= pwdata[7:0];
         if (paddr == ADDR_MSTOP_C)
            module_stop_ctrl_c_reg <= pwdata[7:0];
         if (paddr == ADDR_EXT_STOP)
            extended_clock_stop_reg <= pwdata[1:0];
      end
   end

   // Standby, divider, low-speed and prescaler controls
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         software_standby_select_reg  <= 1'b0;
         settling_count_select_reg    <= STS_RST;
         cpu_clock_divider_select_reg <= DIV_FULL;
         low_speed_select_reg         <= 1'b0;
         prescaler_select_reg         <= 1'b0;
      end
      else if (chip_reset)
      begin
         software_standby_select_reg  <= 1'b0;
         settling_count_select_reg    <= STS_RST;
         cpu_clock_divider_select_reg <= DIV_FULL;
         low_speed_select_reg         <= 1'b0;
         prescaler_select_reg         <= 1'b0;
      end
      else if (wr_en)
      begin
         if (paddr == ADDR_STANDBY_PIN_N_CTRL)
         begin
            software_standby_select_reg <= pwdata[SBY_SOFTWARE_STANDBY_SELECT];
            settling_count_select_reg   <= pwdata[SBY_STS_LO +: 3];
         end
         if (paddr == ADDR_CLK_CTRL)
            cpu_clock_divider_select_reg <= pwdata[2:0];
         if (paddr == ADDR_LPW_CTRL)
            low_speed_select_reg <= pwdata[LPW_LOW_SPEED_SELECT];
         if (paddr == ADDR_PSC_CTRL)
            prescaler_select_reg <= pwdata[PSC_PSS];
      end
   end

   // Per-module stop and clock gate outputs
   assign serial_channel_0_stop = module_stop_ctrl_b_reg[MSB_SCI0];
   assign serial_channel_2_stop = module_stop_ctrl_b_reg[MSB_SCI2];
   assign usb_stop              = module_stop_ctrl_b_reg[MSB_USB];
   assign flash_stop            = module_stop_ctrl_c_reg[MSC_FLASH];
   assign debug_interface_stop  = module_stop_ctrl_c_reg[MSC_DEBUG];
   assign rtc_clock_gate        = extended_clock_stop_reg[EXT_RTC];
   assign usb_clock_gate        = extended_clock_stop_reg[EXT_USB];

   // Checks
   property p_hw_entry;
      @(posedge pclk) disable iff (!presetn)
      standby_pin_n_low |=> state_reg == PDM_HW_STANDBY_PIN_N && io_hiz && chip_reset;
   endproperty
   a_hw_entry: assert property (p_hw_entry) else $error("no hardware standby");

   property p_div_update;
      @(posedge pclk) disable iff (!presetn)
      bus_cycle_end && !reset_any && !standby_pin_n_low
      |=> cpu_clk_div == $past(cpu_clock_divider_select_reg) && dma_clk_div == cpu_clk_div;
   endproperty
   a_div_update: assert property (p_div_update) else $error("divider not taken");

   property p_reset_full;
      @(posedge pclk) disable iff (!presetn)
      reset_any |=> cpu_clk_div == DIV_FULL && chip_reset;
   endproperty
   a_reset_full: assert property (p_reset_full) else $error("speed not reset");

   property p_sleep_in;
      @(posedge pclk) disable iff (!presetn)
      state_reg == PDM_RUN && sleep_req && !software_standby_select_reg
      && !low_speed_select_reg && !reset_any && !standby_pin_n_low
      |=> state_reg == PDM_SLEEP && cpu_halt && clock_supply && osc_enable;
   endproperty
   a_sleep_in: assert property (p_sleep_in) else $error("sleep entry wrong");

   property p_sleep_out;
      @(posedge pclk) disable iff (!presetn)
      state_reg == PDM_SLEEP && !reset_any && !standby_pin_n_low
      |=> (state_reg == PDM_RUN) == $past(sleep_wake) && int_exc_start == $past(sleep_wake);
   endproperty
   a_sleep_out: assert property (p_sleep_out) else $error("sleep wake wrong");

   property p_sw_stop;
      @(posedge pclk) disable iff (!presetn)
      state_reg == PDM_SW_STANDBY_PIN_N |-> !osc_enable && !clock_supply && cpu_halt;
   endproperty
   a_sw_stop: assert property (p_sw_stop) else $error("oscillator running");

   property p_settle_16;
      @(posedge pclk) disable iff (!presetn || reset_any || standby_pin_n_low)
      state_reg == PDM_SW_STANDBY_PIN_N && sw_wake && settling_count_select_reg == STS_16
      |=> (state_reg == PDM_SETTLE && !clock_supply)[*8]
          ##1 (state_reg == PDM_SETTLE)[*8] ##1 (state_reg == PDM_RUN && int_exc_start);
   endproperty
   a_settle_16: assert property (p_settle_16) else $error("settle length wrong");

   property p_rst_standby_pin_n;
      @(posedge pclk) disable iff (!presetn)
      (state_reg inside {PDM_SW_STANDBY_PIN_N, PDM_SETTLE}) && reset_any && !standby_pin_n_low
      |=> state_reg == PDM_RESET && clock_supply && osc_enable;
   endproperty
   a_rst_standby_pin_n: assert property (p_rst_standby_pin_n) else $error("reset wake wrong");

   property p_hw_leave;
      @(posedge pclk) disable iff (!presetn)
      state_reg == PDM_HW_STANDBY_PIN_N && !standby_pin_n_low |=> state_reg == PDM_RESET && osc_enable;
   endproperty
   a_hw_leave: assert property (p_hw_leave) else $error("standby exit wrong");

endmodule

/* testbench/pdm_pin_model.sv */
// Model of the board parts that drive the reset, standby and interrupt pins.
// Assumes the bench asks for pin levels on pclk; reset is stretched here.
`timescale 1ns/100ps
module pdm_pin_model
#(
   parameter int HOLD = 40
)
(
   // Clock
   input  wire logic       pclk,
   // Requested levels
   input  wire logic       rq_res,
   input  wire logic       rq_manual_reset_pin_n,
   input  wire logic       rq_standby_pin_n,
   input  wire logic       rq_nmi,
   input  wire logic [7:0] rq_irq,
   // Pins
   output logic            reset_pin_n,
   output logic            manual_reset_pin_n,
   output logic            standby_pin_n,
   output logic            nmi_req,
   output logic [7:0]      irq_lines
);
   logic [7:0] cnt    = 8'h00;
   logic       standby_pin_n_d = 1'b1;
   logic       res_d  = 1'b1;

   // Keep reset low until the oscillator has had time to settle
   always_ff @(posedge pclk)
   begin
      standby_pin_n_d <= rq_standby_pin_n;
      res_d  <= rq_res;
      if ((rq_standby_pin_n && !standby_pin_n_d) || (!rq_res && res_d))
         cnt <= HOLD[7:0];
      else if (cnt != 8'h00)
         cnt <= cnt - 8'h01;
   end

   // Pin levels
   assign reset_pin_n        = rq_res && (cnt == 8'h00);
   assign manual_reset_pin_n = rq_manual_reset_pin_n;
   // Mode select pins are not driven here; the board keeps them fixed all run
   assign standby_pin_n      = rq_standby_pin_n;
   assign nmi_req            = rq_nmi;
   assign irq_lines          = rq_irq;
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the power-down mode controller.
// Assumes APB reads are answered with pready; pins come from the pin model.
`timescale 1ns/100ps
module tb_top
   import pdm_pkg::*;
;
   localparam int ST[8] = '{20, 24, 28, 32, 36, 40, 2048, 16};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, irq_enable = 8'h00, rq_irq = 8'h00, irq_lines;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic sleep_req = 1'b0, bus_cycle_end = 1'b0, wdt_overflow = 1'b0;
   logic periph_int_req = 1'b0, cpu_int_mask = 1'b0;
   logic rq_res = 1'b1, rq_manual_reset_pin_n = 1'b1, rq_standby_pin_n = 1'b1, rq_nmi = 1'b0;
   logic reset_pin_n, manual_reset_pin_n, standby_pin_n, nmi_req, pready, pslverr;
   logic osc_enable, clock_supply, io_hiz, int_exc_start, serial_channel_0_stop;
   logic serial_channel_2_stop, usb_stop, flash_stop, debug_interface_stop;
   logic rtc_clock_gate, usb_clock_gate, converter_reset;
   logic [2:0] dma_clk_div;
   logic [32:0] expq[$];
   int n_errors = 0;
   int checks   = 0;

   // 250 MHz clock
   always #2 pclk = ~pclk;

   pdm_pin_model pins (.pclk, .rq_res, .rq_manual_reset_pin_n, .rq_standby_pin_n, .rq_nmi, .rq_irq,
      .reset_pin_n, .manual_reset_pin_n, .standby_pin_n, .nmi_req, .irq_lines);

   pdm_power_ctrl #(.SETTLE_8192(ST[0]), .SETTLE_16384(ST[1]), .SETTLE_32768(ST[2]),
      .SETTLE_65536(ST[3]), .SETTLE_131072(ST[4]), .SETTLE_262144(ST[5])) dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
      .prdata, .pready, .pslverr, .reset_pin_n, .manual_reset_pin_n, .standby_pin_n,
      .nmi_req, .irq_lines, .sleep_req, .bus_cycle_end, .wdt_overflow, .irq_enable,
      .periph_int_req, .cpu_int_mask, .cpu_clk_div(), .dma_clk_div, .cpu_halt(),
      .clock_supply, .osc_enable, .chip_reset(), .io_hiz, .converter_reset,
      .reset_exc_start(), .int_exc_start, .serial_channel_0_stop,
      .serial_channel_2_stop, .usb_stop, .flash_stop, .debug_interface_stop,
      .rtc_clock_gate, .usb_clock_gate);

   task chk(input logic [32:0] e, input logic [32:0] g);
      checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   // Compare each read answer with the oldest noted expectation
   always @(posedge pclk)
      if (pready === 1'b1 && psel && !pwrite)
         chk(expq.pop_front(), {pslverr, prdata});

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a stall
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic [32:0] e);
      expq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task slp;
      @(posedge pclk);
      sleep_req <= 1'b1;
      @(posedge pclk);
      sleep_req <= 1'b0;
   endtask

   // Enter software standby, try a disabled line, then time the wake-up
   task settle(input int c);
      int n;
      apb(1'b1, ADDR_STANDBY_PIN_N_CTRL, {24'h0, 1'b1, c[2:0], 4'h0});
      slp();
      rq_irq <= 8'h20;
      cyc(10);
      rd(ADDR_STATUS, 33'h2);
      irq_enable <= 8'h20;
      n = 0;
      while (int_exc_start !== 1'b1 && n < 3000)
      begin
         @(posedge pclk);
         n++;
      end
      chk(33'h1, {32'h0, n >= ST[c] && n <= ST[c] + 6});
      rq_irq     <= 8'h00;
      irq_enable <= 8'h00;
   endtask

   task end_sim;
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      void'($urandom(73));
      cyc(16);
      presetn <= 1'b1;
      cyc(8);
      rd(ADDR_MSTOP_B, 33'h0FF);
      rd(ADDR_MSTOP_C, 33'h0FD);
      rd(ADDR_EXT_STOP, 33'h0);
      r = $urandom;
      apb(1'b1, ADDR_MSTOP_B, {24'h0, r[7:0] | 8'h5E});
      rd(ADDR_MSTOP_B, {25'h0, r[7:0] | 8'h5E});
      chk({30'h0, r[7], r[5], r[0]}, {30'h0, serial_channel_0_stop, serial_channel_2_stop, usb_stop});
      apb(1'b1, ADDR_MSTOP_C, {24'h0, r[15:8] | 8'hFC});
      rd(ADDR_MSTOP_C, {25'h0, r[15:8] | 8'hFC});
      chk({31'h0, r[9:8]}, {31'h0, flash_stop, debug_interface_stop});
      apb(1'b1, ADDR_EXT_STOP, {30'h0, r[17:16]});
      rd(ADDR_EXT_STOP, {31'h0, r[17:16]});
      chk({31'h0, r[17:16]}, {31'h0, rtc_clock_gate, usb_clock_gate});
      rd(8'h20, 33'h100000000);
      apb(1'b1, ADDR_CLK_CTRL, 32'h3);
      rd(ADDR_STATUS, 33'h0);
      @(posedge pclk);
      bus_cycle_end <= 1'b1;
      @(posedge pclk);
      bus_cycle_end <= 1'b0;
      rd(ADDR_STATUS, 33'h30);
      chk(33'h3, {30'h0, dma_clk_div});
      slp();
      rd(ADDR_STATUS, 33'h31);
      cpu_int_mask   <= 1'b1;
      periph_int_req <= 1'b1;
      cyc(6);
      rd(ADDR_STATUS, 33'h31);
      rq_nmi <= 1'b1;
      cyc(8);
      rd(ADDR_STATUS, 33'h30);
      rq_nmi         <= 1'b0;
      periph_int_req <= 1'b0;
      cpu_int_mask   <= 1'b0;
      @(posedge pclk);
      wdt_overflow <= 1'b1;
      @(posedge pclk);
      wdt_overflow <= 1'b0;
      cyc(8);
      rd(ADDR_STATUS, 33'h0);
      rd(ADDR_MSTOP_B, 33'h0FF);
      // External clock, so any code is legal; the 16-state code stands for non-flash parts
      for (int c = 0; c < 8; c++)
         settle(c);
      apb(1'b1, ADDR_STANDBY_PIN_N_CTRL, 32'hF0);
      slp();
      cyc(4);
      rq_manual_reset_pin_n <= 1'b0;
      cyc(6);
      chk(33'h3, {31'h0, osc_enable, clock_supply});
      rq_manual_reset_pin_n <= 1'b1;
      cyc(10);
      rd(ADDR_STATUS, 33'h0);
      rq_res <= 1'b0;
      cyc(12);
      rq_standby_pin_n <= 1'b0;
      cyc(6);
      rd(ADDR_STATUS, 33'h4);
      chk(33'hC, {29'h0, io_hiz, converter_reset, osc_enable, clock_supply});
      rq_standby_pin_n <= 1'b1;
      cyc(2);
      rq_res <= 1'b1;
      cyc(4);
      rd(ADDR_STATUS, 33'h5);
      cyc(40);
      rd(ADDR_STATUS, 33'h0);
      rd(ADDR_MSTOP_B, 33'h0FF);
      end_sim();
   end

   // Cut a hang short
   initial
   begin
      #40000;
      n_errors++;
      end_sim();
   end
endmodule
